// ===== rtl/uio_pkg.sv
package uio_pkg;
  localparam int             ADDR_W          = 5;
  localparam logic [4:0]     OFS_CTRL        = 5'h00;
  localparam logic [4:0]     OFS_LEDS        = 5'h04;
  localparam logic [4:0]     OFS_BUTTONS     = 5'h08;
  localparam logic [4:0]     OFS_DISP_CMD    = 5'h0c;
  localparam logic [4:0]     OFS_DISP_READ   = 5'h10;
  localparam logic [4:0]     OFS_STATUS      = 5'h14;
  localparam int             CTRL_EIGHT_BIT  = 0;
  localparam logic           CTRL_RESET      = 1'b1;
  localparam logic [3:0]     LEDS_N_RESET    = 4'hf;
  localparam int             CMD_RW_BIT      = 8;
  localparam int             CMD_RS_BIT      = 9;
  localparam int             READ_VALID_BIT  = 8;
  localparam int             STAT_BUSY_BIT   = 0;
  localparam int             STAT_EMPTY_BIT  = 1;
  localparam int             STAT_FULL_BIT   = 2;
  localparam int             STAT_COLS_LSB   = 16;
  localparam int             STAT_ROWS_LSB   = 24;
  localparam logic [7:0]     DISP_COLS       = 8'h10;
  localparam logic [3:0]     DISP_ROWS       = 4'h2;
  localparam logic [1:0]     RESP_OKAY       = 2'h0;
  localparam logic [1:0]     RESP_SLVERR     = 2'h2;
  localparam int             FIFO_DEPTH      = 16;
  localparam int             CLK_PERIOD_PS   = 8000;
  localparam int             SETUP_NS        = 60;
  localparam int             STROBE_NS       = 500;
  localparam int             HOLD_NS         = 20;
  localparam int             CNT_W           = 8;
  localparam logic [7:0]     SETUP_CNT       =
    8'((SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0]     STROBE_CNT      =
    8'((STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0]     HOLD_CNT        =
    8'((HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef struct packed {
    logic       rs;
    logic       rw;
    logic [7:0] data;
  } disp_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_PULSE = 4'b0100,
    ST_HOLD  = 4'b1000
  } disp_state_t;
endpackage : uio_pkg

// ===== rtl/user_io_panel_port.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module uio_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_clk_en,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              push = i_in_valid & o_in_ready & i_clk_en;
  wire              pop  = o_out_valid & i_out_ready & i_clk_en;

  assign o_in_ready  = count != PW'(0) + (PW+1)'(DEPTH);
  assign o_out_valid = count != '0;
  assign o_out_data  = mem[rd_ptr];

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= PW'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= PW'(rd_ptr + 1'b1);
      if (push && !pop) count <= (PW+1)'(count + 1'b1);
      else if (pop && !push) count <= (PW+1)'(count - 1'b1);
    end
  end
endmodule : uio_fifo

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// [RULE1] Low general button level means pressed.
// [RULE2] High general button level means released, idle.
// [RULE3] Reset button low resets the whole design; the code leaves the button samples, which only i_reset clears.
// [RULE4] Reset button level is also software readable.
// [RULE5] Four independent indicators driven from software.
// [RULE6] Indicator output low lights it.
// [RULE7] Indicator output high turns it off.
// [RULE8] Display geometry is sixteen columns, two lines.
// [RULE9] Select line high for data, low instruction.
// [RULE10] Direction high reads, display drives the bus.
// [RULE11] Eight-line or four-line transfers, software chosen.
// [RULE12] Lines held stable while the strobe is high.
// [RULE13] Address lines steer direction, select; chip select.
module user_io_panel_port #(
  parameter logic [7:0] SETUP_CYCLES  = uio_pkg::SETUP_CNT,
  parameter logic [7:0] STROBE_CYCLES = uio_pkg::STROBE_CNT,
  parameter logic [7:0] HOLD_CYCLES   = uio_pkg::HOLD_CNT
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_clk_en,
  input  wire logic                       i_design_reset_button_n,
  input  wire logic                       i_general_button_0,
  input  wire logic                       i_general_button_1,
  output logic [3:0]                      o_indicator_n,
  output logic                            o_shared_addr_line_0,
  output logic                            o_shared_addr_line_1,
  output logic                            o_display_select_n,
  output logic                            o_display_enable,
  input  wire logic [7:0]                 i_display_data_lines,
  output logic [7:0]                      o_display_data_lines,
  output logic                            o_display_data_lines_oe,
  input  wire logic [uio_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  output logic [1:0]                      o_bresp,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  input  wire logic [uio_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  output logic                            o_rvalid,
  input  wire logic                       i_rready
);
  import uio_pkg::*;

  logic              rst;
  logic              eight_bit;
  logic [2:0]        pressed;
  logic [7:0]        rd_data;
  logic              rd_valid;
  logic [ADDR_W-1:0] waddr;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  disp_state_t       state;
  logic [7:0]        cnt;
  disp_cmd_t         cur;
  logic              cur_eight;
  logic              first_half;
  logic              q_in_ready;
  logic              q_valid;
  disp_cmd_t         q_data;

  // A pressed reset button clears everything but the readable button samples, its own included.
  assign rst = i_reset | ~i_design_reset_button_n; // [RULE3]

  //////////////////////////////////////////////////////////////////////////////

  wire        wr_go     = !o_awready && !o_wready && !o_bvalid;
  wire        is_cmd    = waddr == OFS_DISP_CMD;
  wire        wr_commit = wr_go && (!is_cmd || q_in_ready);
  wire        wr_mapped = waddr == OFS_CTRL || waddr == OFS_LEDS ||
                          waddr == OFS_BUTTONS || is_cmd ||
                          waddr == OFS_DISP_READ || waddr == OFS_STATUS;
  wire        q_push    = wr_commit && is_cmd && wstrb[0];
  wire        ar_fire   = i_arvalid && o_arready;
  wire        rd_clear  = ar_fire && i_araddr == OFS_DISP_READ;
  wire        cnt_done  = cnt == 8'h01;
  wire        last_half = cur_eight || !first_half;
  wire        rd_done   = state == ST_HOLD && cnt_done && cur.rw && last_half;
  wire        rd_known  = i_araddr == OFS_CTRL || i_araddr == OFS_LEDS ||
                          i_araddr == OFS_BUTTONS ||
                          i_araddr == OFS_DISP_CMD ||
                          i_araddr == OFS_DISP_READ ||
                          i_araddr == OFS_STATUS;
  wire [31:0] stat_word = {4'h0, DISP_ROWS, DISP_COLS, 13'h0000, // [RULE8]
                           !q_in_ready, !q_valid, state != ST_IDLE};
  wire [31:0] rd_word   =
    i_araddr == OFS_CTRL      ? {31'h0, eight_bit} :
    i_araddr == OFS_LEDS      ? {28'h0, ~o_indicator_n} :
    i_araddr == OFS_BUTTONS   ? {29'h0, pressed} :
    i_araddr == OFS_DISP_READ ? {23'h0, rd_valid, rd_data} :
    i_araddr == OFS_STATUS    ? stat_word : 32'h0000_0000;
  // In four-line mode the nibble travels on the upper four lines.
  wire [7:0]  first_out = eight_bit ? q_data.data
                                    : {q_data.data[7:4], 4'h0}; // [RULE11]

  uio_fifo #(
    .WIDTH ($bits(disp_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst       (rst),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (q_push),
    .o_in_ready  (q_in_ready),
    .i_in_data   (wdata[9:0]),
    .o_out_valid (q_valid),
    .i_out_ready (state == ST_IDLE),
    .o_out_data  (q_data)
  );

  //////////////////////////////////////////////////////////////////////////////

  // The reset button sample only obeys the bus reset so it stays readable.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pressed <= 3'h0;
    end else if (i_clk_en) begin
      pressed <= {~i_design_reset_button_n, // [RULE4]
                  ~i_general_button_1, ~i_general_button_0}; // [RULE1] [RULE2]
    end
  end

  always_ff @(posedge i_core_clk or posedge rst) begin
    if (rst) begin
      o_awready     <= 1'b1;
      o_wready      <= 1'b1;
      o_bvalid      <= 1'b0;
      o_bresp       <= RESP_OKAY;
      waddr         <= '0;
      wdata         <= 32'h0000_0000;
      wstrb         <= 4'h0;
      eight_bit     <= CTRL_RESET;
      o_indicator_n <= LEDS_N_RESET;
    end else if (i_clk_en) begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        waddr     <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        wdata    <= i_wdata;
        wstrb    <= i_wstrb;
      end
      if (wr_commit) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        if (waddr == OFS_CTRL && wstrb[0]) begin
          eight_bit <= wdata[CTRL_EIGHT_BIT]; // [RULE11]
        end
        if (waddr == OFS_LEDS && wstrb[0]) begin
          o_indicator_n <= ~wdata[3:0]; // [RULE5] [RULE6] [RULE7]
        end
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge rst) begin
    if (rst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= RESP_OKAY;
      rd_valid  <= 1'b0;
    end else if (i_clk_en) begin
      if (ar_fire) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= rd_word;
        o_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
      // A read that completes as software drains the old byte still counts.
      if (rd_done) rd_valid <= 1'b1;
      else if (rd_clear) rd_valid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_core_clk or posedge rst) begin
    if (rst) begin
      state                   <= ST_IDLE;
      cnt                     <= 8'h00;
      cur                     <= '0;
      cur_eight               <= 1'b1;
      first_half              <= 1'b0;
      rd_data                 <= 8'h00;
      o_shared_addr_line_0    <= 1'b0;
      o_shared_addr_line_1    <= 1'b0;
      o_display_select_n      <= 1'b1;
      o_display_enable        <= 1'b0;
      o_display_data_lines    <= 8'h00;
      o_display_data_lines_oe <= 1'b0;
    end else if (i_clk_en) begin
      if (state != ST_IDLE && !cnt_done) cnt <= cnt - 8'h01;
      case (state)
        ST_IDLE: begin
          if (q_valid) begin
            cur                     <= q_data;
            cur_eight               <= eight_bit;
            first_half              <= 1'b1;
            o_shared_addr_line_0    <= q_data.rw; // [RULE13] [RULE10]
            o_shared_addr_line_1    <= q_data.rs; // [RULE13] [RULE9]
            o_display_select_n      <= 1'b0; // [RULE13]
            o_display_data_lines_oe <= !q_data.rw; // [RULE10]
            o_display_data_lines    <= first_out;
            cnt                     <= SETUP_CYCLES;
            state                   <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_done) begin
            o_display_enable <= 1'b1;
            cnt              <= STROBE_CYCLES;
            state            <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (cnt_done) begin
            if (cur.rw && cur_eight) rd_data <= i_display_data_lines;
            else if (cur.rw && first_half) begin
              rd_data[7:4] <= i_display_data_lines[7:4]; // [RULE11]
            end else if (cur.rw) rd_data[3:0] <= i_display_data_lines[7:4];
            o_display_enable <= 1'b0; // [RULE12]
            cnt              <= HOLD_CYCLES;
            state            <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt_done && !last_half) begin
            first_half           <= 1'b0;
            o_display_data_lines <= {cur.data[3:0], 4'h0}; // [RULE11]
            cnt                  <= SETUP_CYCLES;
            state                <= ST_SETUP;
          end else if (cnt_done) begin
            o_display_select_n      <= 1'b1; // [RULE13]
            o_display_data_lines_oe <= 1'b0;
            state                   <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (rst);

  sequence s_led_write;
    i_clk_en && wr_commit && waddr == OFS_LEDS && wstrb[0];
  endsequence
  sequence s_strobe_high;
    o_display_enable && $past(o_display_enable);
  endsequence

  a_led_active_low: assert property ( // [RULE6] [RULE7] [RULE5]
    s_led_write |=> o_indicator_n == ~$past(wdata[3:0]))
    else $error("Indicator level does not follow the written pattern.");
  a_button_pressed: assert property ( // [RULE1]
    i_clk_en && !i_general_button_0 |=> pressed[0])
    else $error("Low button level not seen as pressed.");
  a_button_idle: assert property ( // [RULE2]
    i_clk_en && i_general_button_1 |=> !pressed[1])
    else $error("High button level not seen as released.");
  a_reset_button: assert property ( // [RULE3]
    disable iff (i_reset) !i_design_reset_button_n |=>
      o_display_select_n && !o_display_enable && state == ST_IDLE)
    else $error("Reset button did not reset the display engine.");
  a_reset_readable: assert property ( // [RULE4]
    disable iff (i_reset)
      i_clk_en |=> pressed[2] == !$past(i_design_reset_button_n))
    else $error("Reset button level not readable.");
  a_geometry_shown: assert property ( // [RULE8]
    ar_fire && i_clk_en && i_araddr == OFS_STATUS |=>
      o_rdata[STAT_COLS_LSB +: 8] == 8'h10 &&
      o_rdata[STAT_ROWS_LSB +: 4] == 4'h2)
    else $error("Display geometry wrong in status.");
  a_select_level: assert property ( // [RULE9] [RULE13]
    o_display_enable |-> o_shared_addr_line_1 == cur.rs &&
                         o_shared_addr_line_0 == cur.rw)
    else $error("Address lines do not match the transfer.");
  a_read_release: assert property ( // [RULE10]
    !o_display_select_n && o_shared_addr_line_0 |->
      !o_display_data_lines_oe)
    else $error("Bus driven during a display read.");
  a_nibble_split: assert property ( // [RULE11]
    i_clk_en && state == ST_HOLD && cnt_done && !last_half |=>
      state == ST_SETUP && o_display_data_lines[7:4] == cur.data[3:0])
    else $error("Second nibble not sent in four-line mode.");
  a_strobe_stable: assert property ( // [RULE12]
    s_strobe_high |-> $stable(o_display_data_lines) &&
      $stable(o_shared_addr_line_0) && $stable(o_shared_addr_line_1))
    else $error("Lines changed while the strobe was high.");
  a_select_access: assert property ( // [RULE13]
    state == ST_IDLE |-> o_display_select_n && !o_display_enable)
    else $error("Chip select active outside an access.");
endmodule : user_io_panel_port

`default_nettype wire

// ===== testbench/lcd_model.sv
`timescale 1ns/1ps
`default_nettype none

module lcd_model #(
  parameter logic [7:0] READ_BYTE = 8'h5c
) (
  input  wire logic       i_clk,
  input  wire logic       i_four_line,
  input  wire logic       i_select_n,
  input  wire logic       i_strobe,
  input  wire logic       i_read,
  input  wire logic       i_data_sel,
  input  wire logic [7:0] i_bus,
  input  wire logic       i_bus_oe,
  output logic      [7:0] o_bus,
  output var int          o_n_bad
);
  logic [8:0]  log_q[$];
  logic [11:0] held;
  logic        strobe_q = 1'b0;
  logic        low_half = 1'b0;
  logic [7:0]  last     = 8'h00;
  logic [3:0]  nib;
  int          n_bad    = 0;
  wire  [11:0] lines = {i_data_sel, i_read, i_bus_oe, i_select_n,
                        i_read ? 8'h00 : i_bus};

  ////////////////////////////////////////////////////////////////////////////
  // Off a read the bus shows a changing pattern, so stale data never passes.
  assign nib     = low_half ? READ_BYTE[3:0] : READ_BYTE[7:4];
  assign o_bus   = (!i_select_n && i_read) ?
                   (i_four_line ? {nib, ~last[3:0]} : READ_BYTE) : ~last;
  assign o_n_bad = n_bad;

  always @(posedge i_clk) begin
    last     <= o_bus;
    strobe_q <= i_strobe;
    held     <= lines;
    if (i_strobe && (i_select_n || i_bus_oe === i_read)) begin
      n_bad <= n_bad + 1;
    end
    if (i_strobe && strobe_q && lines !== held) begin
      n_bad <= n_bad + 1;
    end
    if (strobe_q && !i_strobe) begin
      if (!i_read) begin
        log_q.push_back({i_data_sel, i_bus});
      end else if (i_four_line) begin
        low_half <= !low_half;
      end
    end
  end
endmodule : lcd_model

`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import uio_pkg::*;
  localparam logic [7:0] RD_BYTE = 8'h5c;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rst_btn_n = 1'b1;
  logic        btn0 = 1'b1;
  logic        btn1 = 1'b1;
  logic        four = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  ind_n;
  logic        rw, rs, sel_n, en, oe;
  logic [7:0]  bus_out, bus_in;
  logic [4:0]  awaddr = 5'h00;
  logic [4:0]  araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] seed = 32'd76761;
  logic [8:0]  expq[$];
  int          n_mismatch = 0;
  int          n_compared = 0;

  user_io_panel_port #(.SETUP_CYCLES(8'h01), .STROBE_CYCLES(8'h14),
    .HOLD_CYCLES(8'h01)) uut (
    .i_core_clk(clk), .i_reset(rst), .i_clk_en(ce),
    .i_design_reset_button_n(rst_btn_n), .i_general_button_0(btn0),
    .i_general_button_1(btn1), .o_indicator_n(ind_n),
    .o_shared_addr_line_0(rw), .o_shared_addr_line_1(rs),
    .o_display_select_n(sel_n), .o_display_enable(en),
    .i_display_data_lines(bus_in), .o_display_data_lines(bus_out),
    .o_display_data_lines_oe(oe), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

  lcd_model #(.READ_BYTE(RD_BYTE)) lcd (
    .i_clk(clk), .i_four_line(four), .i_select_n(sel_n), .i_strobe(en),
    .i_read(rw), .i_data_sel(rs), .i_bus(bus_out), .i_bus_oe(oe),
    .o_bus(bus_in), .o_n_bad());

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] geom(logic [2:0] f);
    return {4'h0, DISP_ROWS, DISP_COLS, 13'h0, f};
  endfunction : geom

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    chk(r, er, "bresp");
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    chk(rresp, er, "rresp");
    rready <= 1'b0;
  endtask : rd

  task automatic wait_idle();
    logic [31:0] s;
    do begin
      rd(OFS_STATUS, RESP_OKAY, s);
    end while (s[1:0] !== 2'b10);
    chk(s[2:0], 3'b010, "idle status");
  endtask : wait_idle

  // Four-line mode puts each nibble on lines 7:4 with lines 3:0 low.
  task automatic push(input logic r, input logic [7:0] b, input logic f);
    if (!f) expq.push_back({r, b});
    else begin
      expq.push_back({r, b[7:4], 4'h0});
      expq.push_back({r, b[3:0], 4'h0});
    end
  endtask : push

  task automatic drain();
    chk(lcd.log_q.size(), expq.size(), "transfer count");
    while (expq.size() > 0 && lcd.log_q.size() > 0) begin
      chk(lcd.log_q.pop_front(), expq.pop_front(), "display write");
    end
    expq.delete();
    lcd.log_q.delete();
  endtask : drain

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk = ~clk;
  end

  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    logic [31:0] r, c;
    logic [3:0]  v;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(ind_n, 4'hf, "leds off at reset");
    chk(sel_n, 1'b1, "idle select");
    rd(OFS_STATUS, RESP_OKAY, r);
    chk(r, geom(3'b010), "status");
    rd(OFS_CTRL, RESP_OKAY, r);
    chk(r, 32'h1, "ctrl reset");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'(rnd());
      wr(OFS_LEDS, {28'h0, v}, RESP_OKAY);
      chk(ind_n, v ^ 4'hf, "led pins");
      rd(OFS_LEDS, RESP_OKAY, r);
      chk(r, {28'h0, v}, "led readback");
    end
    for (int i = 0; i < 4; i++) begin
      btn0 <= i[0];
      btn1 <= i[1];
      repeat (4) @(posedge clk);
      rd(OFS_BUTTONS, RESP_OKAY, r);
      chk(r[2:0] ^ {1'b0, i[1:0]}, 3'b011, "buttons");
    end
    wr(5'h18, rnd(), RESP_SLVERR);
    rd(5'h1c, RESP_SLVERR, r);
    chk(r, 32'h0, "unmapped data");
    for (int m = 0; m < 2; m++) begin
      four <= m[0];
      wr(OFS_CTRL, {31'h0, ~m[0]}, RESP_OKAY);
      for (int k = 0; k < 6; k++) begin
        c = rnd();
        wr(OFS_DISP_CMD, {22'h0, c[9], 1'b0, c[7:0]}, RESP_OKAY);
        push(c[9], c[7:0], m[0]);
      end
      wr(OFS_DISP_CMD, {22'h0, c[0], 1'b1, 8'h00}, RESP_OKAY);
      wait_idle();
      rd(OFS_DISP_READ, RESP_OKAY, r);
      chk(r, {23'h0, 1'b1, RD_BYTE}, "read byte");
      rd(OFS_DISP_READ, RESP_OKAY, r);
      chk(r[8], 1'b0, "read valid clears");
      drain();
    end
    four <= 1'b0;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    for (int k = 0; k < 24; k++) begin
      wr(OFS_DISP_CMD, {24'h0, 8'(k)}, RESP_OKAY);
      push(1'b0, 8'(k), 1'b0);
    end
    rd(OFS_STATUS, RESP_OKAY, r);
    chk(r[2:0], 3'b101, "fifo full and busy");
    // A low clock enable must hold the strobe far past its normal length.
    wait (en === 1'b1);
    @(posedge clk);
    ce <= 1'b0;
    repeat (30) @(posedge clk);
    chk({en, sel_n}, 2'b10, "frozen strobe");
    ce <= 1'b1;
    wait_idle();
    drain();
    wr(OFS_LEDS, 32'ha, RESP_OKAY);
    rst_btn_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(ind_n, 4'hf, "button reset");
    rst_btn_n <= 1'b1;
    rd(OFS_LEDS, RESP_OKAY, r);
    chk(r, 32'h0, "leds cleared");
    chk(lcd.o_n_bad, 32'h0, "strobe lines");
    stop_test();
  end
endmodule : tb

`default_nettype wire
